/* rtl/cl_list_unit.sv */
/*
 * execution unit for the four circular list instructions.
 * assumes a word port held until ack, rdata/fault valid with ack, aligned base, one op.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - opcodes 64, 65 are add top, bottom
// - opcodes 66, 67 are remove top, bottom
// - add element is full 32-bit register value
// - full list: nothing written, overflow flag set
// - add bumps tally, moves pointer, stores element
// - add top: pre-decrement top, wrap to max
// - add bottom: store, then post-increment with wrap
// - header written only after faultless slot store
// - empty remove: overflow, register untouched
// - remove moves pointer, reads element, drops tally
// - remove top: read at top, then increment
// - remove bottom: pre-decrement with wrap, then read
// - header after read, register after header
// - add gives 0100 when full, 0000 when it completes, cc kept on a fault
module cl_list_unit
    import cl_list_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i, // one-cycle instruction issue
    input wire logic [7:0] opcode_i,
    input wire logic [31:0] element_i, // first operand register contents
    input wire logic [31:0] list_addr_i, // second operand address
    input wire logic mem_ack_i,
    input wire logic mem_fault_i, // valid with ack
    input wire logic [31:0] mem_rdata_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    output logic busy_o,
    output logic done_o,
    output logic [3:0] cc_o,
    output logic reg_we_o,
    output logic [31:0] reg_wdata_o,
    output logic fault_o
);
    // whole unit state, registered in one place
    typedef struct packed {
        cl_fsm_type state;
        logic [1:0] sel; // operation select
        logic [31:0] base; // list base address
        logic [31:0] elem; // add element or removed element
        logic [15:0] count; // slot count
        logic [15:0] tally; // used slots
        logic [15:0] top; // current top pointer
        logic [15:0] bot; // next bottom pointer
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic busy;
        logic done;
        logic [3:0] cc;
        logic reg_we;
        logic [31:0] reg_wdata;
        logic fault;
        logic slot_ok; // element access finished clean
        logic hdr_done; // both header words written
        logic wrote; // any memory write this instruction
    } cl_state_type;
    cl_state_type s;
    cl_state_type next_s;
    logic is_add; // add versus remove
    logic legal_op; // opcode is one of the four
    logic [15:0] max_slot; // wrap limit
    logic [15:0] rd_top; // pointers as read from header
    logic [15:0] rd_bot;
    logic [15:0] new_ptr; // pointer after the move
    logic [15:0] slot_idx; // slot accessed
    assign is_add = ~s.sel[1];
    // the four opcodes share their upper six bits, the low two select
    assign legal_op = (opcode_i[7:2] == CL_OP_ADD_TOP[7:2]);
    assign max_slot = s.count - 16'h0001;
    assign rd_top = mem_rdata_i[CL_HI_LSB +: 16];
    assign rd_bot = mem_rdata_i[CL_LO_LSB +: 16];
    // pointer arithmetic for the chosen end
    always_comb begin
        new_ptr = 16'h0000;
        slot_idx = 16'h0000;
        unique case (s.sel)
            CL_SEL_ADD_TOP: begin
                new_ptr = (rd_top == 16'h0000) ? max_slot : rd_top - 16'h0001;
                slot_idx = new_ptr;
            end
            CL_SEL_ADD_BOT: begin
                slot_idx = rd_bot;
                new_ptr = (rd_bot >= max_slot) ? 16'h0000 : rd_bot + 16'h0001;
            end
            CL_SEL_REM_TOP: begin
                slot_idx = rd_top;
                new_ptr = (rd_top >= max_slot) ? 16'h0000 : rd_top + 16'h0001;
            end
            CL_SEL_REM_BOT: begin
                new_ptr = (rd_bot == 16'h0000) ? max_slot : rd_bot - 16'h0001;
                slot_idx = new_ptr;
            end
        endcase
    end

    // next state of the whole unit
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.reg_we = 1'b0;
        unique case (s.state)
            CL_IDLE: begin
                // issue ignored while busy or for foreign opcodes
                if (start_i && legal_op) begin
                    next_s.sel = opcode_i[1:0];
                    next_s.base = list_addr_i;
                    next_s.elem = element_i;
                    next_s.busy = 1'b1;
                    next_s.fault = 1'b0;
                    next_s.slot_ok = 1'b0;
                    next_s.hdr_done = 1'b0;
                    next_s.wrote = 1'b0;
                    next_s.req = 1'b1;
                    next_s.we = 1'b0;
                    next_s.addr = list_addr_i + CL_HDR0_OFS;
                    next_s.state = CL_RD_HDR0;
                end
            end
            CL_RD_HDR0: begin
                if (mem_ack_i) begin
                    next_s.count = mem_rdata_i[CL_HI_LSB +: 16];
                    next_s.tally = mem_rdata_i[CL_LO_LSB +: 16];
                    if (mem_fault_i) begin
                        next_s.req = 1'b0;
                        next_s.fault = 1'b1;
                        next_s.state = CL_FINISH;
                    end else if (is_add ? (mem_rdata_i[CL_LO_LSB +: 16] ==
                                           mem_rdata_i[CL_HI_LSB +: 16])
                                        : (mem_rdata_i[CL_LO_LSB +: 16] == 16'h0000)) begin
                        // full add or empty remove: stop with no write
                        next_s.req = 1'b0;
                        next_s.cc = CL_CC_OVF;
                        next_s.state = CL_FINISH;
                    end else begin
                        next_s.addr = s.base + CL_HDR1_OFS;
                        next_s.state = CL_RD_HDR1;
                    end
                end
            end
            CL_RD_HDR1: begin
                if (mem_ack_i) begin
                    if (mem_fault_i) begin
                        next_s.req = 1'b0;
                        next_s.fault = 1'b1;
                        next_s.state = CL_FINISH;
                    end else begin
                        next_s.top = s.sel[0] ? rd_top : new_ptr;
                        next_s.bot = s.sel[0] ? new_ptr : rd_bot;
                        next_s.addr = s.base + CL_SLOT0_OFS + {14'h0000, slot_idx, 2'h0};
                        next_s.we = is_add;
                        next_s.wdata = s.elem;
                        next_s.state = CL_SLOT;
                    end
                end
            end
            CL_SLOT: begin
                if (mem_ack_i) begin
                    next_s.wrote = s.wrote | s.we;
                    if (mem_fault_i) begin
                        // header untouched, so software can retry
                        next_s.req = 1'b0;
                        next_s.we = 1'b0;
                        next_s.fault = 1'b1;
                        next_s.state = CL_FINISH;
                    end else begin
                        if (!is_add) begin
                            next_s.elem = mem_rdata_i;
                        end
                        next_s.slot_ok = 1'b1;
                        next_s.tally = is_add ? s.tally + 16'h0001 : s.tally - 16'h0001;
                        next_s.we = 1'b1;
                        next_s.addr = s.base + CL_HDR1_OFS;
                        next_s.wdata = {s.top, s.bot};
                        next_s.state = CL_WR_HDR1;
                    end
                end
            end
            CL_WR_HDR1: begin
                if (mem_ack_i) begin
                    next_s.wrote = 1'b1;
                    if (mem_fault_i) begin
                        next_s.req = 1'b0;
                        next_s.we = 1'b0;
                        next_s.fault = 1'b1;
                        next_s.state = CL_FINISH;
                    end else begin
                        next_s.addr = s.base + CL_HDR0_OFS;
                        next_s.wdata = {s.count, s.tally};
                        next_s.state = CL_WR_HDR0;
                    end
                end
            end
            CL_WR_HDR0: begin
                if (mem_ack_i) begin
                    next_s.req = 1'b0;
                    next_s.we = 1'b0;
                    if (mem_fault_i) begin
                        next_s.fault = 1'b1;
                    end else begin
                        next_s.hdr_done = 1'b1;
                        next_s.cc = (is_add || s.tally == 16'h0000) ? CL_CC_NONE : CL_CC_GT;
                    end
                    next_s.state = CL_FINISH;
                end
            end
            CL_FINISH: begin
                // register only after the header is safely updated
                next_s.reg_we = s.hdr_done && !is_add;
                next_s.reg_wdata = s.elem;
                next_s.done = 1'b1;
                next_s.busy = 1'b0;
                next_s.state = CL_IDLE;
            end
            default: begin
                next_s.state = CL_IDLE;
            end
        endcase
    end
    // single register for all state
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign mem_req_o = s.req;
    assign mem_we_o = s.we;
    assign mem_addr_o = s.addr;
    assign mem_wdata_o = s.wdata;
    assign busy_o = s.busy;
    assign done_o = s.done;
    assign cc_o = s.cc;
    assign reg_we_o = s.reg_we;
    assign reg_wdata_o = s.reg_wdata;
    assign fault_o = s.fault;
    // checks on the sequence
    default clocking cl_cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_add_decode;
        (s.state == CL_IDLE && start_i && opcode_i[7:1] == CL_OP_ADD_TOP[7:1])
            |=> (busy_o && mem_req_o && !mem_we_o && is_add);
    endproperty
    a_add_decode: assert property (p_add_decode) else $error("add opcode not taken");
    property p_rem_decode;
        (s.state == CL_IDLE && start_i && opcode_i[7:1] == CL_OP_REM_TOP[7:1])
            |=> (busy_o && mem_addr_o == $past(list_addr_i) && !is_add);
    endproperty
    a_rem_decode: assert property (p_rem_decode) else $error("remove opcode not taken");
    property p_add_data;
        (s.state == CL_SLOT && mem_we_o) |-> (mem_wdata_o == s.elem && is_add);
    endproperty
    a_add_data: assert property (p_add_data) else $error("slot store data wrong");
    property p_ovf_nowrite;
        (done_o && cc_o == CL_CC_OVF && !fault_o) |-> (!s.wrote && !reg_we_o);
    endproperty
    a_ovf_nowrite: assert property (p_ovf_nowrite) else $error("write on overflow");
    property p_hdr_after_slot;
        (mem_req_o && mem_we_o && (s.state == CL_WR_HDR1 || s.state == CL_WR_HDR0))
            |-> s.slot_ok;
    endproperty
    a_hdr_after_slot: assert property (p_hdr_after_slot) else $error("header before slot");
    property p_reg_after_hdr;
        reg_we_o |-> ($past(s.hdr_done) && !is_add);
    endproperty
    a_reg_after_hdr: assert property (p_reg_after_hdr) else $error("register too early");
    property p_rem_cc;
        (s.state == CL_WR_HDR0 && mem_ack_i && !mem_fault_i && !is_add)
            |=> (cc_o == ((s.tally == 16'h0000) ? CL_CC_NONE : CL_CC_GT)) ##1 done_o;
    endproperty
    a_rem_cc: assert property (p_rem_cc) else $error("remove condition code wrong");
    property p_add_tally;
        (s.state == CL_WR_HDR0 && is_add) |-> (mem_wdata_o[15:0] <= s.count &&
                                                mem_wdata_o[15:0] != 16'h0000);
    endproperty
    a_add_tally: assert property (p_add_tally) else $error("add tally out of range");
    c_add_ok: cover property (done_o && is_add && cc_o == CL_CC_NONE && !fault_o);
    c_add_full: cover property (done_o && is_add && cc_o == CL_CC_OVF);
    c_rem_ok: cover property (reg_we_o && cc_o == CL_CC_GT);
    c_rem_empty: cover property (done_o && !is_add && cc_o == CL_CC_OVF);
endmodule
`default_nettype wire

/* pkg/cl_list_pkg.sv */
/*
 * constants for the circular list add/remove execution unit:
 * opcodes, header layout, condition codes and state encoding.
 * assumes big-endian halfword packing inside each header fullword.
 */
`default_nettype none
package cl_list_pkg;
    // opcodes of the four list operations
    localparam logic [7:0] CL_OP_ADD_TOP = 8'h64;
    localparam logic [7:0] CL_OP_ADD_BOT = 8'h65;
    localparam logic [7:0] CL_OP_REM_TOP = 8'h66;
    localparam logic [7:0] CL_OP_REM_BOT = 8'h67;
    // low two opcode bits select the operation
    localparam logic [1:0] CL_SEL_ADD_TOP = 2'h0;
    localparam logic [1:0] CL_SEL_ADD_BOT = 2'h1;
    localparam logic [1:0] CL_SEL_REM_TOP = 2'h2;
    localparam logic [1:0] CL_SEL_REM_BOT = 2'h3;
    // header: word 0 = slot count | tally, word 1 = top | next bottom
    localparam logic [31:0] CL_HDR0_OFS = 32'h0000_0000;
    localparam logic [31:0] CL_HDR1_OFS = 32'h0000_0004;
    localparam logic [31:0] CL_SLOT0_OFS = 32'h0000_0008;
    localparam int CL_HI_LSB = 16;
    localparam int CL_LO_LSB = 0;
    // condition codes c v g l
    localparam logic [3:0] CL_CC_NONE = 4'h0;
    localparam logic [3:0] CL_CC_OVF = 4'h4;
    localparam logic [3:0] CL_CC_GT = 4'h2;
    // states, gray along the usual path up to finish; finish back to idle flips two bits
    typedef enum logic [2:0] {
        CL_IDLE = 3'h0,
        CL_RD_HDR0 = 3'h1,
        CL_RD_HDR1 = 3'h3,
        CL_SLOT = 3'h2,
        CL_WR_HDR1 = 3'h6,
        CL_WR_HDR0 = 3'h7,
        CL_FINISH = 3'h5
    } cl_fsm_type;
endpackage
`default_nettype wire

/* verification/cl_mem_model.sv */
/*
 * behavioural main memory for the circular list unit: 256 words,
 * programmable ack latency and a single armed fault address.
 * assumes the requester holds req/addr/we/wdata steady until ack.
 */
`timescale 1ns/1ps
`default_nettype none
module cl_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [1:0] lat_i, // cycles of wait before ack
    input wire logic fault_en_i,
    input wire logic [31:0] fault_addr_i,
    output logic ack_o,
    output logic fault_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:255]; // word store, also loaded by the bench
    logic [1:0] wait_cnt; // cycles the current request has waited
    logic [31:0] noise; // read bus outside an ack is never stale data
    // ack may come in the request's own cycle when latency is zero
    assign ack_o = req_i && (wait_cnt >= lat_i);
    // fault only with ack, and only on the armed word
    assign fault_o = ack_o && fault_en_i && (addr_i == fault_addr_i);
    assign rdata_o = (ack_o && !we_i) ? mem[addr_i[9:2]] : noise;
    // latency counter, noise pattern and word writes
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= 2'h0;
            noise <= 32'h5a5a_a5a5;
        end else begin
            noise <= {~noise[30:0], noise[31]};
            wait_cnt <= (ack_o || !req_i) ? 2'h0 : wait_cnt + 2'h1;
            // a faulted write leaves the word as it was
            if (ack_o && we_i && !fault_o) begin
                mem[addr_i[9:2]] <= wdata_i;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/circular_list_add_remove_bench.sv */
/*
 * self-checking bench for cl_list_unit against a behavioural memory.
 * assumes a list of five slots at 0x100 and one instruction at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module circular_list_add_remove_bench;
    import cl_list_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic [7:0] opcode_i = 8'h00;
    logic [31:0] element_i = 32'h0;
    logic [31:0] list_addr_i = 32'h0000_0100; // word aligned base
    logic mem_ack_i, mem_fault_i, mem_req_o, mem_we_o, busy_o, done_o, reg_we_o, fault_o;
    logic [31:0] mem_rdata_i, mem_addr_o, mem_wdata_o, reg_wdata_o;
    logic [3:0] cc_o;
    logic [1:0] lat = 2'h0; // memory latency for the next instruction
    logic fault_en = 1'b0;
    logic [31:0] fault_addr = 32'h0;
    int bad_count = 0;
    int checked = 0;
    int seed = 52894;
    logic [37:0] exp_q[$]; // {cc, fault, reg_we, reg_wdata} per done
    logic [37:0] seen_exp;
    int cnt_r, tally_r, top_r, bot_r; // reference list header
    logic [31:0] slot_r [0:4];
    logic [3:0] cc_r;
    logic [31:0] rnd;
    cl_list_unit DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i),
        .opcode_i(opcode_i), .element_i(element_i), .list_addr_i(list_addr_i),
        .mem_ack_i(mem_ack_i), .mem_fault_i(mem_fault_i), .mem_rdata_i(mem_rdata_i),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .busy_o(busy_o), .done_o(done_o), .cc_o(cc_o),
        .reg_we_o(reg_we_o), .reg_wdata_o(reg_wdata_o), .fault_o(fault_o));
    cl_mem_model u_mem (.clk_i(core_clk_i), .rst_i(rst_i), .req_i(mem_req_o),
        .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .lat_i(lat),
        .fault_en_i(fault_en), .fault_addr_i(fault_addr), .ack_o(mem_ack_i),
        .fault_o(mem_fault_i), .rdata_o(mem_rdata_i));
    // 100 mhz clock
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // single comparison point
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // empty list of five slots, slots hold junk
    task automatic init_list;
        cnt_r = 5; tally_r = 0; top_r = 0; bot_r = 0; cc_r = CL_CC_NONE;
        u_mem.mem[64] = 32'h0005_0000; // count | tally
        u_mem.mem[65] = 32'h0; // top | next bottom
        for (int i = 0; i < 5; i++) begin
            slot_r[i] = 32'hbad0_0000 + i;
            u_mem.mem[66 + i] = slot_r[i];
        end
    endtask
    // issue one instruction now (just after an edge), note expectations, wait for done
    task automatic run_op(input logic [1:0] sel, input logic [31:0] e, input bit poke,
        input bit flt);
        logic [37:0] exp;
        logic [31:0] v;
        bit full;
        int idx, i;
        v = 32'h0;
        full = sel[1] ? (tally_r == 0) : (tally_r == cnt_r);
        // slot touched: pre-step for add top / remove bottom, wrap to count-1
        case (sel)
            2'h0: idx = (top_r == 0) ? cnt_r - 1 : top_r - 1;
            2'h1: idx = bot_r;
            2'h2: idx = top_r;
            default: idx = (bot_r == 0) ? cnt_r - 1 : bot_r - 1;
        endcase
        if (flt) begin
            fault_en = 1'b1;
            fault_addr = 32'h108 + 32'(4 * idx);
            exp = {cc_r, 1'b1, 1'b0, 32'h0}; // header and register untouched
        end else if (full) begin
            cc_r = CL_CC_OVF;
            exp = {cc_r, 2'b00, 32'h0};
        end else begin
            if (!sel[1]) begin
                slot_r[idx] = e;
                tally_r++;
                cc_r = CL_CC_NONE;
            end else begin
                v = slot_r[idx];
                tally_r--;
                cc_r = (tally_r != 0) ? CL_CC_GT : CL_CC_NONE;
            end
            case (sel)
                2'h0: top_r = idx;
                2'h1: bot_r = (bot_r >= cnt_r - 1) ? 0 : bot_r + 1;
                2'h2: top_r = (top_r >= cnt_r - 1) ? 0 : top_r + 1;
                default: bot_r = idx;
            endcase
            exp = {cc_r, 1'b0, sel[1], v};
        end
        exp_q.push_back(exp);
        start_i = 1'b1;
        opcode_i = CL_OP_ADD_TOP | {6'h0, sel};
        element_i = e;
        @(posedge core_clk_i);
        #1;
        // issue pulse ends here; optional stray start while busy, must be ignored
        for (i = 0; i < 200; i++) begin
            start_i = poke && (i == 0);
            if (poke) begin
                opcode_i = CL_OP_REM_BOT;
            end
            @(posedge core_clk_i);
            #1;
            if (done_o === 1'b1) break;
        end
        if (i == 200) begin
            bad_count++;
            test_done();
        end
        fault_en = 1'b0;
        chk("hdr0", u_mem.mem[64], {16'(cnt_r), 16'(tally_r)});
        chk("hdr1", u_mem.mem[65], {16'(top_r), 16'(bot_r)});
        if (!sel[1] && !full && !flt) chk("slot", u_mem.mem[66 + idx], e);
        rnd = $random(seed);
        lat = rnd[1:0];
    endtask
    // result monitor: each done takes the oldest note, sampled mid-cycle where settled
    always @(negedge core_clk_i) begin
        if (done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("done_o", {31'h0, done_o}, 32'h0);
            end else begin
                seen_exp = exp_q.pop_front();
                chk("cc_o", {28'h0, cc_o}, {28'h0, seen_exp[37:34]});
                chk("fault_o", {31'h0, fault_o}, {31'h0, seen_exp[33]});
                chk("reg_we_o", {31'h0, reg_we_o}, {31'h0, seen_exp[32]});
                if (seen_exp[32]) chk("reg_wdata_o", reg_wdata_o, seen_exp[31:0]);
            end
        end
    end
    // watchdog, far beyond the few thousand cycles expected
    initial begin
        #200000;
        bad_count++;
        $display("watchdog expired");
        test_done();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        init_list();
        run_op(2'h3, 32'h0, 0, 0); // empty remove
        run_op(2'h0, 32'h1, 0, 0); // top wrap from zero
        run_op(2'h0, 32'h2, 1, 0);
        run_op(2'h0, 32'h3, 0, 0);
        run_op(2'h1, 32'h4, 0, 0);
        run_op(2'h1, 32'h5, 0, 0);
        run_op(2'h1, 32'h6, 0, 0); // full list
        run_op(2'h2, 32'h0, 0, 0);
        run_op(2'h3, 32'h0, 0, 0);
        run_op(2'h2, 32'h0, 0, 0);
        $display("directed list sequence done");
        start_i = 1'b1;
        opcode_i = 8'h63; // not a list opcode
        @(posedge core_clk_i);
        #1;
        start_i = 1'b0;
        repeat (3) begin
            @(posedge core_clk_i);
            #1;
            chk("busy_o", {31'h0, busy_o}, 32'h0);
        end
        $display("illegal opcode test done");
        run_op(2'h0, 32'h77, 0, 1); // faulted slot store
        run_op(2'h3, 32'h0, 0, 1); // faulted slot read
        $display("memory fault test done");
        repeat (80) begin
            rnd = $random(seed);
            run_op(rnd[1:0], $random(seed), 0, 0);
        end
        $display("random list traffic done");
        test_done();
    end
endmodule
`default_nettype wire
